// ---- design/irq_agg_pkg.sv ----
package irq_agg_pkg;

    // sizes of the aggregator
    localparam int NUM_SOURCES = 32;
    localparam int NUM_CHANNELS = 4;
    localparam int GROUP_SIZE = 4;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int BE_W = 4;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h60;
    localparam logic [ADDR_W-1:0] OFS_LATCHED = 8'h64;
    localparam logic [ADDR_W-1:0] OFS_TRIG_TYPE = 8'h68;
    localparam logic [ADDR_W-1:0] OFS_POLARITY = 8'h6c;
    localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h70;
    localparam logic [ADDR_W-1:0] OFS_LEVEL = 8'h74;
    localparam logic [ADDR_W-1:0] OFS_PENDING = 8'h78;

    // source numbering: first half cable and almost flags, second half fifo flags
    localparam int SRC_A_BASE = 0;
    localparam int SRC_B_BASE = 16;
    localparam int POS_ENVELOPE = 0;
    localparam int POS_TX_ALMOST_EMPTY = 1;
    localparam int POS_RX_ALMOST_FULL = 2;
    localparam int POS_SPARE = 3;
    localparam int POS_TX_EMPTY = 0;
    localparam int POS_TX_FULL = 1;
    localparam int POS_RX_EMPTY = 2;
    localparam int POS_RX_FULL = 3;

    // reset values and fixed read values
    localparam logic [DATA_W-1:0] RST_ENABLE = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_LATCHED = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_POLARITY = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_READDATA = 32'h0000_0000;
    localparam logic [DATA_W-1:0] TRIG_TYPE_VALUE = 32'hffff_ffff;
    localparam logic POL_RISING = 1'b0;

    // fifo flags of one channel, all active high
    typedef struct packed {
        logic tx_empty;
        logic tx_full;
        logic rx_empty;
        logic rx_full;
        logic tx_almost_empty;
        logic rx_almost_full;
    } chan_flags_t;

    // one avalon request as seen by the slave
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
        logic [BE_W-1:0] byteenable;
    } av_req_t;

    // bus slave handshake states, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

endpackage

// ---- design/pin_level_sync.sv ----
module pin_level_sync import irq_agg_pkg::*; #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;
    logic [WIDTH-1:0] agree;

    // a change counts only once stages two and three agree
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_bit
            assign agree[b] = ~(state_reg.s2[b] ^ state_reg.s3[b]);
        end
    endgenerate

    always_comb begin
        state_next = state_reg;
        state_next.s1 = pin_in;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        state_next.stable = (agree & state_reg.s3) | (~agree & state_reg.stable);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign level_out = state_reg.stable;

endmodule

// ---- design/edge_event_detect.sv ----
module edge_event_detect import irq_agg_pkg::*; #(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] level,
    input wire logic [WIDTH-1:0] polarity,
    output logic [WIDTH-1:0] event_pulse
);

    typedef struct packed {
        logic primed;
        logic [WIDTH-1:0] prev;
        logic [WIDTH-1:0] evt;
    } edge_state_t;

    edge_state_t state_reg;
    edge_state_t state_next;
    logic [WIDTH-1:0] hit;

    // rising when polarity is zero, falling when one; levels never fire
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_bit
            assign hit[b] = (polarity[b] == POL_RISING) ? (~state_reg.prev[b] & level[b])
                                                        : (state_reg.prev[b] & ~level[b]);
        end
    endgenerate

    // first cycle after reset only loads the history, so flags true at reset do not fire
    always_comb begin
        state_next = state_reg;
        state_next.primed = 1'b1;
        state_next.prev = level;
        state_next.evt = state_reg.primed ? hit : '0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign event_pulse = state_reg.evt;

endmodule

// ---- design/quad_channel_irq_aggregator.sv ----
// Function
// - thirty-two sources, each enabled on its own
// - sources 0-15: envelope, tx almost-empty, rx almost-full, spare
// - sources 16-31: tx empty, tx full, rx empty, rx full
// - bit n of every register is source n
// - detection on edges only, never on level
// - polarity register picks rising or falling per source
// - all sources merge into one request output
// - enable one allows, zero blocks the source
// - latched bit reads one after the chosen edge
// - latched bit holds until software writes one
// - clearing enable also clears the latched bit
// - clearing disabled or idle source changes nothing
// - trigger type register reads all sources edge
module quad_channel_irq_aggregator import irq_agg_pkg::*; #(
    parameter int CHANNELS = NUM_CHANNELS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [BE_W-1:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire chan_flags_t [CHANNELS-1:0] chan_flags,
    input wire logic [CHANNELS-1:0] receive_envelope_input,
    input wire logic [CHANNELS-1:0] receive_spare_input,
    output logic irq_request
);

    // all state of the aggregator
    typedef struct packed {
        bus_state_t bus_state;
        logic waitrequest;
        logic [DATA_W-1:0] readdata;
        logic [DATA_W-1:0] enable;
        logic [DATA_W-1:0] latched;
        logic [DATA_W-1:0] polarity;
        logic irq;
    } agg_state_t;

    agg_state_t state_reg;
    agg_state_t state_next;

    av_req_t req;
    logic [CHANNELS-1:0] envelope_level;
    logic [CHANNELS-1:0] spare_level;
    logic [NUM_SOURCES-1:0] src_level;
    logic [NUM_SOURCES-1:0] src_event;
    logic [DATA_W-1:0] wr_mask;
    logic [DATA_W-1:0] clear_bits;
    logic [DATA_W-1:0] pending;
    logic access_now;
    logic wr_enable;
    logic wr_polarity;
    logic wr_clear;

    // gather the bus signals into one request
    always_comb begin
        req.read = avs_read;
        req.write = avs_write;
        req.address = avs_address;
        req.writedata = avs_writedata;
        req.byteenable = avs_byteenable;
    end

    // cable inputs arrive from the pins and need synchronising
    pin_level_sync #(
        .WIDTH(2 * CHANNELS)
    ) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .pin_in({receive_spare_input, receive_envelope_input}),
        .level_out({spare_level, envelope_level})
    );

    // map each channel onto its two groups of four sources
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            assign src_level[SRC_A_BASE + GROUP_SIZE * ch + POS_ENVELOPE] = envelope_level[ch];
            assign src_level[SRC_A_BASE + GROUP_SIZE * ch + POS_TX_ALMOST_EMPTY] =
                chan_flags[ch].tx_almost_empty;
            assign src_level[SRC_A_BASE + GROUP_SIZE * ch + POS_RX_ALMOST_FULL] =
                chan_flags[ch].rx_almost_full;
            assign src_level[SRC_A_BASE + GROUP_SIZE * ch + POS_SPARE] = spare_level[ch];
            assign src_level[SRC_B_BASE + GROUP_SIZE * ch + POS_TX_EMPTY] = chan_flags[ch].tx_empty;
            assign src_level[SRC_B_BASE + GROUP_SIZE * ch + POS_TX_FULL] = chan_flags[ch].tx_full;
            assign src_level[SRC_B_BASE + GROUP_SIZE * ch + POS_RX_EMPTY] = chan_flags[ch].rx_empty;
            assign src_level[SRC_B_BASE + GROUP_SIZE * ch + POS_RX_FULL] = chan_flags[ch].rx_full;
        end
    endgenerate

    // one edge detector per source, polarity taken from software
    edge_event_detect #(
        .WIDTH(NUM_SOURCES)
    ) u_edge (
        .clk(clk),
        .rst(rst),
        .level(src_level),
        .polarity(state_reg.polarity),
        .event_pulse(src_event)
    );

    // byte lanes turn into a bit mask for partial writes
    genvar lane;
    generate
        for (lane = 0; lane < BE_W; lane++) begin : g_lane
            assign wr_mask[8 * lane +: 8] = {8{req.byteenable[lane]}};
        end
    endgenerate

    // a write lands only at the edge where waitrequest is seen low
    assign access_now = (state_reg.bus_state == BUS_ACK);
    assign wr_enable = access_now & req.write & (req.address[ADDR_W-1:2] == OFS_ENABLE[ADDR_W-1:2]);
    assign wr_polarity = access_now & req.write & (req.address[ADDR_W-1:2] == OFS_POLARITY[ADDR_W-1:2]);
    assign wr_clear = access_now & req.write &
                      ((req.address[ADDR_W-1:2] == OFS_LATCHED[ADDR_W-1:2]) |
                       (req.address[ADDR_W-1:2] == OFS_CLEAR[ADDR_W-1:2]));

    // only ones clear; zeros and masked lanes leave bits alone
    assign clear_bits = wr_clear ? (req.writedata & wr_mask) : '0;

    // only enabled latched bits count toward the request
    assign pending = state_reg.latched & state_reg.enable;

    // read multiplexer: unmapped offsets read zero
    function automatic logic [DATA_W-1:0] read_value(
        input logic [ADDR_W-1:0] addr,
        input agg_state_t s,
        input logic [NUM_SOURCES-1:0] lvl,
        input logic [DATA_W-1:0] pnd
    );
        logic [DATA_W-1:0] val;
        val = RST_READDATA;
        case (addr[ADDR_W-1:2])
            OFS_ENABLE[ADDR_W-1:2]: val = s.enable;
            OFS_LATCHED[ADDR_W-1:2]: val = s.latched;
            OFS_TRIG_TYPE[ADDR_W-1:2]: val = TRIG_TYPE_VALUE;
            OFS_POLARITY[ADDR_W-1:2]: val = s.polarity;
            OFS_LEVEL[ADDR_W-1:2]: val = lvl;
            OFS_PENDING[ADDR_W-1:2]: val = pnd;
            default: val = RST_READDATA;
        endcase
        return val;
    endfunction

    // bus handshake, register updates and request, in one pass
    always_comb begin
        state_next = state_reg;

        // one wait cycle, then a single acknowledge cycle
        case (state_reg.bus_state)
            BUS_IDLE: begin
                if (req.read | req.write) begin
                    state_next.bus_state = BUS_ACK;
                    state_next.waitrequest = 1'b0;
                    state_next.readdata = req.read ? read_value(req.address, state_reg, src_level, pending)
                                                   : RST_READDATA;
                end else begin
                    state_next.waitrequest = 1'b1;
                end
            end
            BUS_ACK: begin
                // the master drops or renews its request after this edge
                state_next.bus_state = BUS_IDLE;
                state_next.waitrequest = 1'b1;
            end
            default: begin
                state_next.bus_state = BUS_IDLE;
                state_next.waitrequest = 1'b1;
            end
        endcase

        // enable and polarity are plain read-write words
        if (wr_enable) begin
            state_next.enable = (state_reg.enable & ~wr_mask) | (req.writedata & wr_mask);
        end
        if (wr_polarity) begin
            state_next.polarity = (state_reg.polarity & ~wr_mask) | (req.writedata & wr_mask);
        end

        // a new edge beats a clear in the same cycle; only enabled sources latch
        state_next.latched = (state_reg.latched & ~clear_bits) | (src_event & state_reg.enable);

        // dropping an enable wipes the latch, so a clear on it finds nothing to do
        state_next.latched = state_next.latched & state_next.enable;

        // registered so the pin comes straight from a flop
        state_next.irq = |(state_next.latched & state_next.enable);
    end

    // reset puts the slave in wait and every source disabled, rising edge
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg.bus_state <= BUS_IDLE;
            state_reg.waitrequest <= 1'b1;
            state_reg.readdata <= RST_READDATA;
            state_reg.enable <= RST_ENABLE;
            state_reg.latched <= RST_LATCHED;
            state_reg.polarity <= RST_POLARITY;
            state_reg.irq <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from state flops
    assign avs_readdata = state_reg.readdata;
    assign avs_waitrequest = state_reg.waitrequest;
    assign irq_request = state_reg.irq;

endmodule

// ---- bench/bridge_irq_model.sv ----
module bridge_irq_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic local_irq,
    input wire logic local_enable,
    output logic pci_int
);
    timeunit 1ns;
    timeprecision 1ps;
    // host must open the local input gate, else the request is never seen
    always_ff @(posedge clk) begin
        if (rst) begin
            pci_int <= 1'b0;
        end else begin
            pci_int <= local_irq && local_enable;
        end
    end
endmodule

// ---- bench/irq_agg_properties.sv ----
module irq_agg_properties import irq_agg_pkg::*; #(
    parameter int CHANNELS = NUM_CHANNELS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [BE_W-1:0] avs_byteenable,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire chan_flags_t [CHANNELS-1:0] chan_flags,
    input wire logic [CHANNELS-1:0] receive_envelope_input,
    input wire logic [CHANNELS-1:0] receive_spare_input,
    input wire logic irq_request
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [CHANNELS*8-1:0] ins;
    logic [CHANNELS*8-1:0] ins_reg;
    logic [3:0] quiet_reg;
    logic req;
    logic acked;
    assign ins = {chan_flags, receive_envelope_input, receive_spare_input};
    assign req = avs_read || avs_write;
    assign acked = avs_write && !avs_waitrequest;
    // pin edges need several cycles to land, so count cycles since any source moved
    always_ff @(posedge clk) begin
        ins_reg <= ins;
        if (rst || ins != ins_reg) begin
            quiet_reg <= 4'h0;
        end else if (quiet_reg != 4'hf) begin
            quiet_reg <= quiet_reg + 4'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_taken; req && avs_waitrequest; endsequence
    sequence s_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
    sequence s_full_wr(a, d);
        acked && avs_address[7:2] == a && avs_writedata == d && avs_byteenable == 4'hf;
    endsequence
    property p_one_wait; s_taken |=> s_ack; endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait not one cycle");
    property p_wait_cause; $fell(avs_waitrequest) |-> $past(req); endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
    property p_reset_state; $fell(rst) |-> avs_waitrequest && !irq_request && avs_readdata == 32'h0; endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
    property p_trig_ro;
        s_taken ##0 (avs_read && avs_address[7:2] == OFS_TRIG_TYPE[7:2]) |=> avs_readdata == TRIG_TYPE_VALUE;
    endproperty
    a_trig_ro: assert property (p_trig_ro) else $error("trigger type wrong");
    property p_disable_quiet; s_full_wr(OFS_ENABLE[7:2], 32'h0) |-> ##2 !irq_request [*2]; endproperty
    a_disable_quiet: assert property (p_disable_quiet) else $error("irq after disable");
    property p_clear_drop;
        quiet_reg > 4'h7 ##0 s_full_wr(OFS_LATCHED[7:2], 32'hffff_ffff) |-> ##2 !irq_request;
    endproperty
    a_clear_drop: assert property (p_clear_drop) else $error("irq kept after clear");
    property p_rise_cause; $rose(irq_request) |-> quiet_reg < 4'hc; endproperty
    a_rise_cause: assert property (p_rise_cause) else $error("irq without edge");
    property p_fall_cause; $fell(irq_request) |-> $past(acked) || $past(acked, 2); endproperty
    a_fall_cause: assert property (p_fall_cause) else $error("irq fell unasked");
endmodule

bind quad_channel_irq_aggregator irq_agg_properties #(.CHANNELS(CHANNELS)) u_irq_agg_properties (
    .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .chan_flags, .receive_envelope_input, .receive_spare_input, .irq_request);

// ---- bench/quad_channel_irq_aggregator_tb.sv ----
module quad_channel_irq_aggregator_tb import irq_agg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, read, write, loc_en, waitreq, irq, pci_int;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0] be;
    logic [3:0] env;
    logic [3:0] spare;
    chan_flags_t [3:0] flags;
    int n_mismatch = 0;
    int comparisons = 0;
    quad_channel_irq_aggregator u_quad_channel_irq_aggregator (.clk(clk), .rst(rst), .avs_address(addr),
        .avs_read(read), .avs_write(write), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(waitreq), .chan_flags(flags), .receive_envelope_input(env),
        .receive_spare_input(spare), .irq_request(irq));
    bridge_irq_model u_bridge_irq_model (.clk(clk), .rst(rst), .local_irq(irq), .local_enable(loc_en),
        .pci_int(pci_int));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // request held until waitrequest is seen low; no fixed latency assumed
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] m);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        be <= m;
        write <= 1'b1;
        do @(posedge clk); while (waitreq !== 1'b0);
        write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        read <= 1'b1;
        do @(posedge clk); while (waitreq !== 1'b0);
        read <= 1'b0;
        chk("readdata", exp, rdata);
    endtask
    task automatic ck_irq(input logic e);
        chk("irq_request", {31'h0, e}, {31'h0, irq});
    endtask
    // one source level; the wait covers the pin synchroniser
    task automatic src(input int n, input logic v);
        int c;
        int p;
        c = (n % 16) / 4;
        p = n % 4;
        @(posedge clk);
        if (n >= 16) begin
            flags[c][5-p] <= v;
        end else if (p == 1 || p == 2) begin
            flags[c][2-p] <= v;
        end else if (p == 0) begin
            env[c] <= v;
        end else begin
            spare[c] <= v;
        end
        repeat (8) @(posedge clk);
    endtask
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard, far beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
    initial begin
        {rst, read, write, loc_en} = 4'h8;
        {addr, wdata, be, env, spare} = '0;
        flags = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(8'h60, 32'h0);
        rd(8'h64, 32'h0);
        rd(8'h6c, 32'h0);
        wr(8'h68, 32'h0, 4'hf);
        rd(8'h68, 32'hffff_ffff);
        rd(8'h00, 32'h0);
        wr(8'h6c, 32'hffff_ffff, 4'h3);
        rd(8'h6c, 32'h0000_ffff);
        wr(8'h6c, 32'h0, 4'hf);
        wr(8'h60, 32'hffff_ffff, 4'hf);
        // every source: rising latch, held level, falling latch
        for (int n = 0; n < 32; n++) begin
            src(n, 1'b1);
            rd(8'h64, 32'h1 << n);
            ck_irq(1'b1);
            wr(8'h64, 32'h0, 4'hf);
            rd(8'h64, 32'h1 << n);
            wr(8'h64, 32'hffff_ffff, 4'hf);
            repeat (8) @(posedge clk);
            rd(8'h64, 32'h0);
            ck_irq(1'b0);
            wr(8'h6c, 32'h1 << n, 4'hf);
            src(n, 1'b0);
            rd(8'h64, 32'h1 << n);
            wr(8'h70, 32'h1 << n, 4'hf);
            wr(8'h6c, 32'h0, 4'hf);
            rd(8'h64, 32'h0);
        end
        src(16, 1'b1);
        // live levels and pending word, bit n per source
        rd(8'h74, 32'h0001_0000);
        rd(8'h78, 32'h0001_0000);
        chk("pci_int", 32'h0, {31'h0, pci_int});
        loc_en <= 1'b1;
        repeat (2) @(posedge clk);
        chk("pci_int", 32'h1, {31'h0, pci_int});
        wr(8'h60, 32'h0, 4'hf);
        rd(8'h64, 32'h0);
        ck_irq(1'b0);
        src(17, 1'b1);
        rd(8'h64, 32'h0);
        ck_irq(1'b0);
        wr(8'h64, 32'hffff_ffff, 4'hf);
        rd(8'h60, 32'h0);
        wr(8'h60, 32'h0002_0000, 4'hf);
        rd(8'h64, 32'h0);
        // a fresh edge after enabling does latch; a masked clear lane leaves it
        src(17, 1'b0);
        src(17, 1'b1);
        rd(8'h64, 32'h0002_0000);
        ck_irq(1'b1);
        wr(8'h64, 32'hffff_ffff, 4'h3);
        rd(8'h64, 32'h0002_0000);
        rd(8'h78, 32'h0002_0000);
        wr(8'h6c, 32'hffff_ffff, 4'hf);
        rd(8'h64, 32'h0002_0000);
        // reset in mid-run, flags still high, must not leave a false edge
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(8'h6c, 32'h0);
        rd(8'h60, 32'h0);
        rd(8'h64, 32'h0);
        rd(8'h74, 32'h0003_0000);
        ck_irq(1'b0);
        conclude();
    end
endmodule
